// ==== verilog/cpm_defines.svh ====
`ifndef CPM_DEFINES_SVH
`define CPM_DEFINES_SVH
// register byte offsets
`define CPM_OFF_GPR        8'h00
`define CPM_OFF_A7         8'h3C
`define CPM_OFF_PC         8'h40
`define CPM_OFF_USP        8'h44
`define CPM_OFF_ISP        8'h48
`define CPM_OFF_MSP        8'h4C
`define CPM_OFF_PSW        8'h50
`define CPM_OFF_VBR        8'h54
`define CPM_OFF_SFC        8'h58
`define CPM_OFF_DFC        8'h5C
`define CPM_OFF_ICACHE_CONTROL       8'h60
`define CPM_OFF_ICACHE_OP_ADDRESS       8'h64
// status word fields
`define CPM_PSW_T1         15
`define CPM_PSW_T0         14
`define CPM_PSW_S          13
`define CPM_PSW_M          12
`define CPM_PSW_IPM_HI     10
`define CPM_PSW_IPM_LO     8
`define CPM_PSW_X          4
`define CPM_PSW_N          3
`define CPM_PSW_Z          2
`define CPM_PSW_V          1
`define CPM_PSW_C          0
`define CPM_PSW_MASK       16'hF71F
`define CPM_PSW_RESET      16'h2700
// cache control fields
`define CPM_ICACHE_CONTROL_EN        0
`define CPM_ICACHE_CONTROL_FRZ       1
`define CPM_ICACHE_CONTROL_CLRE      2
`define CPM_ICACHE_CONTROL_CLRA      3
`define CPM_ICACHE_CONTROL_RW_MASK   32'h0000_0003
// space codes
`define CPM_FC_UDATA       3'h1
`define CPM_FC_UPROG       3'h2
`define CPM_FC_SDATA       3'h5
`define CPM_FC_SPROG       3'h6
`define CPM_FC_IDLE        3'h0
// bus answers
`define CPM_RESP_OKAY      2'h0
`define CPM_RESP_SLVERR    2'h2
`endif

// ==== verilog/cpm_pkg.sv ====
package cpm_pkg;
   typedef enum logic [1:0] {CPM_SZ_BYTE, CPM_SZ_WORD, CPM_SZ_LONG, CPM_SZ_QUAD} cpm_size_e;
   typedef enum logic {CPM_R_IDLE, CPM_R_DATA} cpm_rd_e;
   typedef logic [31:0] cpm_word_t;
endpackage

// ==== verilog/cpm_regs.sv ====
// Functional notes
// - sixteen 32-bit general registers: eight data, eight address
// - data registers serve bit, field, byte, long and quad operands
// - address registers act as stack or base, word and long operations
// - any of sixteen registers selectable as index register
// - 32-bit program counter and two separate 32-bit supervisor stack pointers
// - 16-bit status word holds 3-bit interrupt mask and XNZVC flags
// - status word holds two trace bits, supervisor bit, master bit
// - trace-all set: trace trap after every completed instruction
// - flow-trace set: trace trap only after change-of-flow instructions
// - 32-bit vector base locates the exception table at run time
// - three space-code outputs give supervisor/user and program/data each bus cycle
// - two 3-bit alternate space-code registers redirect supervisor accesses
// - 32-bit cache control register controls and reports instruction cache
// - cache address register supplies address for addressed cache operations
// - bit fields are 1 to 32 consecutive bits
// - decimal operands packed two digits per byte or unpacked one
`timescale 1ns/1ps
`default_nettype none
`include "cpm_defines.svh"
module cpm_regs #(
   parameter int ADDR_W = 8
) (
   input  wire logic                 aclk,            // core clock
   input  wire logic                 aresetn,         // sync reset, low
   input  wire logic [ADDR_W-1:0]    s_awaddr,        // write address
   input  wire logic                 s_awvalid,       // write address valid
   output logic                      s_awready,       // write address ready
   input  wire logic [31:0]          s_wdata,         // write data
   input  wire logic [3:0]           s_wstrb,         // byte enables
   input  wire logic                 s_wvalid,        // write data valid
   output logic                      s_wready,        // write data ready
   output logic [1:0]                s_bresp,         // write answer
   output logic                      s_bvalid,        // write answer valid
   input  wire logic                 s_bready,        // write answer ready
   input  wire logic [ADDR_W-1:0]    s_araddr,        // read address
   input  wire logic                 s_arvalid,       // read address valid
   output logic                      s_arready,       // read address ready
   output logic [31:0]               s_rdata,         // read data
   output logic [1:0]                s_rresp,         // read answer
   output logic                      s_rvalid,        // read answer valid
   input  wire logic                 s_rready,        // read answer ready
   input  wire logic                 opd_req,         // operand fetch strobe
   input  wire logic [3:0]           opd_sel,         // register 0-7 data, 8-15 addr
   input  wire cpm_pkg::cpm_size_e   opd_size,        // operand size
   input  wire logic [4:0]           bf_offset,       // field offset from msb
   input  wire logic [4:0]           bf_len,          // field length, 0 means 32
   input  wire logic                 bcd_packed,      // 1 packed, 0 unpacked
   output logic                      opd_valid,       // operand results valid
   output logic [63:0]               opd_value,       // sized operand
   output logic [31:0]               opd_field,       // right aligned bit field
   output logic [6:0]                opd_decimal,     // decimal value of low byte
   input  wire logic                 wb_en,           // register writeback strobe
   input  wire logic [3:0]           wb_sel,          // writeback register
   input  wire cpm_pkg::cpm_size_e   wb_size,         // writeback size
   input  wire logic [31:0]          wb_data,         // writeback value
   input  wire logic                 instr_done,      // instruction completed
   input  wire logic                 instr_flow,      // it changed flow
   output logic                      trace_trap,      // trace trap request pulse
   input  wire logic                 vec_req,         // vector lookup strobe
   input  wire logic [7:0]           vec_num,         // vector number
   output logic                      vec_valid,       // vector address valid
   output logic [31:0]               vec_addr,        // vector entry address
   input  wire logic                 bus_cycle,       // bus cycle under way
   input  wire logic                 bus_prog,        // program space access
   input  wire logic                 bus_alt_src,     // use alternate source code
   input  wire logic                 bus_alt_dst,     // use alternate dest code
   output logic [2:0]                space_code_outputs, // address space code
   output logic [15:0]               status_word,     // current status word
   output logic                      icache_enable,   // cache enabled
   output logic                      icache_freeze,   // cache frozen
   output logic                      icache_clr_entry,// clear one entry pulse
   output logic                      icache_clr_all,  // clear whole cache pulse
   output logic [31:0]               icache_clr_addr  // address for entry clear
);
   if (ADDR_W < 7) begin : g_chk
      $error("ADDR_W too small for register map");
   end

   ////////////////////////////////////////////////////////////////////////////
   cpm_pkg::cpm_word_t gpr_r [0:14];
   logic [31:0]        pc_r, usp_r, isp_r, msp_r, vbr_r, icache_control_r, icache_op_address_r;
   logic [15:0]        psw_r;
   logic [2:0]         sfc_r, dfc_r;
   logic [31:0]        a7_act;
   logic [31:0]        opd_reg, opd_pair;

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // active stack pointer behind A7
   always_comb begin
      if (!psw_r[`CPM_PSW_S]) begin
         a7_act = usp_r;
      end else if (psw_r[`CPM_PSW_M]) begin
         a7_act = msp_r;
      end else begin
         a7_act = isp_r;
      end
   end

   function automatic logic [31:0] reg_of(input logic [3:0] idx);
      return (idx == 4'hF) ? a7_act : gpr_r[idx];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus slave
   logic [ADDR_W-1:0] aw_addr_r, wa, ra;
   logic [31:0]       w_data_r;
   logic [3:0]        w_strb_r;
   logic              aw_full_r, w_full_r, do_write, aw_full_nxt, w_full_nxt, wr_hit;
   cpm_pkg::cpm_rd_e  rd_state_r;
   logic [31:0]       rd_val;
   logic              rd_hit;

   assign do_write    = aw_full_r & w_full_r & ~s_bvalid;
   assign aw_full_nxt = do_write ? 1'b0 : (aw_full_r | (s_awvalid & s_awready));
   assign w_full_nxt  = do_write ? 1'b0 : (w_full_r | (s_wvalid & s_wready));
   assign wa          = {aw_addr_r[ADDR_W-1:2], 2'b00};
   assign ra          = {s_araddr[ADDR_W-1:2], 2'b00};
   assign wr_hit      = (wa <= ADDR_W'(`CPM_OFF_ICACHE_OP_ADDRESS));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         s_awready <= 1'b0;
         s_wready  <= 1'b0;
         aw_addr_r <= '0;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
      end else begin
         aw_full_r <= aw_full_nxt;
         w_full_r  <= w_full_nxt;
         s_awready <= ~aw_full_nxt;
         s_wready  <= ~w_full_nxt;
         if (s_awvalid & s_awready) begin
            aw_addr_r <= s_awaddr;
         end
         if (s_wvalid & s_wready) begin
            w_data_r <= s_wdata;
            w_strb_r <= s_wstrb;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_bvalid <= 1'b0;
         s_bresp  <= `CPM_RESP_OKAY;
      end else if (do_write) begin
         s_bvalid <= 1'b1;
         s_bresp  <= wr_hit ? `CPM_RESP_OKAY : `CPM_RESP_SLVERR;
      end else if (s_bready) begin
         s_bvalid <= 1'b0;
      end
   end

   always_comb begin
      rd_hit = 1'b1;
      rd_val = 32'h0000_0000;
      if (ra <= ADDR_W'(`CPM_OFF_A7)) begin
         rd_val = reg_of(ra[5:2]);
      end else begin
         case (ra)
            ADDR_W'(`CPM_OFF_PC):   rd_val = pc_r;
            ADDR_W'(`CPM_OFF_USP):  rd_val = usp_r;
            ADDR_W'(`CPM_OFF_ISP):  rd_val = isp_r;
            ADDR_W'(`CPM_OFF_MSP):  rd_val = msp_r;
            ADDR_W'(`CPM_OFF_PSW):  rd_val = {16'h0000, psw_r};
            ADDR_W'(`CPM_OFF_VBR):  rd_val = vbr_r;
            ADDR_W'(`CPM_OFF_SFC):  rd_val = {29'h0, sfc_r};
            ADDR_W'(`CPM_OFF_DFC):  rd_val = {29'h0, dfc_r};
            ADDR_W'(`CPM_OFF_ICACHE_CONTROL): rd_val = icache_control_r;
            ADDR_W'(`CPM_OFF_ICACHE_OP_ADDRESS): rd_val = icache_op_address_r;
            default:                rd_hit = 1'b0;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_r <= cpm_pkg::CPM_R_IDLE;
         s_arready  <= 1'b0;
         s_rvalid   <= 1'b0;
         s_rdata    <= 32'h0000_0000;
         s_rresp    <= `CPM_RESP_OKAY;
      end else begin
         case (rd_state_r)
            cpm_pkg::CPM_R_IDLE: begin
               s_arready <= 1'b1;
               if (s_arvalid & s_arready) begin
                  s_arready  <= 1'b0;
                  s_rvalid   <= 1'b1;
                  s_rdata    <= rd_val;
                  s_rresp    <= rd_hit ? `CPM_RESP_OKAY : `CPM_RESP_SLVERR;
                  rd_state_r <= cpm_pkg::CPM_R_DATA;
               end
            end
            cpm_pkg::CPM_R_DATA: begin
               if (s_rready) begin
                  s_rvalid   <= 1'b0;
                  s_arready  <= 1'b1;
                  rd_state_r <= cpm_pkg::CPM_R_IDLE;
               end
            end
            default: rd_state_r <= cpm_pkg::CPM_R_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // general registers: writeback port first, bus write wins a collision
   for (genvar gi = 0; gi < 15; gi++) begin : g_gpr
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            gpr_r[gi] <= 32'h0000_0000;
         end else begin
            if (wb_en && wb_sel == 4'(gi)) begin
               if (gi < 8) begin
                  case (wb_size)
                     cpm_pkg::CPM_SZ_BYTE: gpr_r[gi][7:0]  <= wb_data[7:0];
                     cpm_pkg::CPM_SZ_WORD: gpr_r[gi][15:0] <= wb_data[15:0];
                     default:              gpr_r[gi]       <= wb_data;
                  endcase
               end else if (wb_size == cpm_pkg::CPM_SZ_WORD) begin
                  gpr_r[gi] <= {{16{wb_data[15]}}, wb_data[15:0]};
               end else if (wb_size != cpm_pkg::CPM_SZ_BYTE) begin
                  gpr_r[gi] <= wb_data;
               end
            end
            if (do_write && wa == ADDR_W'(`CPM_OFF_GPR + 4 * gi)) begin
               gpr_r[gi] <= merge(gpr_r[gi], w_data_r, w_strb_r);
            end
         end
      end
   end

   // stack pointers and program counter
   logic wb_a7;
   logic [31:0] wb_a7_val;
   assign wb_a7     = wb_en && wb_sel == 4'hF && wb_size != cpm_pkg::CPM_SZ_BYTE;
   assign wb_a7_val = (wb_size == cpm_pkg::CPM_SZ_WORD) ? {{16{wb_data[15]}}, wb_data[15:0]}
                                                        : wb_data;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         usp_r <= 32'h0000_0000;
         isp_r <= 32'h0000_0000;
         msp_r <= 32'h0000_0000;
         pc_r  <= 32'h0000_0000;
      end else begin
         if (wb_a7 && !psw_r[`CPM_PSW_S]) usp_r <= wb_a7_val;
         if (wb_a7 && psw_r[`CPM_PSW_S] && !psw_r[`CPM_PSW_M]) isp_r <= wb_a7_val;
         if (wb_a7 && psw_r[`CPM_PSW_S] && psw_r[`CPM_PSW_M]) msp_r <= wb_a7_val;
         if (do_write && wa == ADDR_W'(`CPM_OFF_A7)) begin
            if (!psw_r[`CPM_PSW_S]) usp_r <= merge(usp_r, w_data_r, w_strb_r);
            else if (psw_r[`CPM_PSW_M]) msp_r <= merge(msp_r, w_data_r, w_strb_r);
            else isp_r <= merge(isp_r, w_data_r, w_strb_r);
         end
         if (do_write && wa == ADDR_W'(`CPM_OFF_USP)) usp_r <= merge(usp_r, w_data_r, w_strb_r);
         if (do_write && wa == ADDR_W'(`CPM_OFF_ISP)) isp_r <= merge(isp_r, w_data_r, w_strb_r);
         if (do_write && wa == ADDR_W'(`CPM_OFF_MSP)) msp_r <= merge(msp_r, w_data_r, w_strb_r);
         if (do_write && wa == ADDR_W'(`CPM_OFF_PC)) pc_r <= merge(pc_r, w_data_r, w_strb_r);
      end
   end

   // status word, vector base, alternate codes, cache registers
   logic [31:0] psw_merged;
   assign psw_merged = merge({16'h0000, psw_r}, w_data_r, w_strb_r);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         psw_r <= `CPM_PSW_RESET;
         vbr_r <= 32'h0000_0000;
         sfc_r <= 3'h0;
         dfc_r <= 3'h0;
         icache_op_address_r <= 32'h0000_0000;
         icache_control_r <= 32'h0000_0000;
      end else if (do_write) begin
         if (wa == ADDR_W'(`CPM_OFF_PSW)) begin
            psw_r <= psw_merged[15:0] & `CPM_PSW_MASK;
         end
         if (wa == ADDR_W'(`CPM_OFF_VBR)) vbr_r <= merge(vbr_r, w_data_r, w_strb_r);
         if (wa == ADDR_W'(`CPM_OFF_SFC) && w_strb_r[0]) sfc_r <= w_data_r[2:0];
         if (wa == ADDR_W'(`CPM_OFF_DFC) && w_strb_r[0]) dfc_r <= w_data_r[2:0];
         if (wa == ADDR_W'(`CPM_OFF_ICACHE_OP_ADDRESS)) icache_op_address_r <= merge(icache_op_address_r, w_data_r, w_strb_r);
         if (wa == ADDR_W'(`CPM_OFF_ICACHE_CONTROL)) begin
            icache_control_r <= merge(icache_control_r, w_data_r, w_strb_r) & `CPM_ICACHE_CONTROL_RW_MASK;
         end
      end
   end

   // cache control outputs; clear bits act once and read back zero
   logic icache_control_wr;
   assign icache_control_wr = do_write && wa == ADDR_W'(`CPM_OFF_ICACHE_CONTROL) && w_strb_r[0];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         icache_enable    <= 1'b0;
         icache_freeze    <= 1'b0;
         icache_clr_entry <= 1'b0;
         icache_clr_all   <= 1'b0;
         icache_clr_addr  <= 32'h0000_0000;
         status_word      <= `CPM_PSW_RESET;
      end else begin
         icache_enable    <= icache_control_r[`CPM_ICACHE_CONTROL_EN];
         icache_freeze    <= icache_control_r[`CPM_ICACHE_CONTROL_FRZ];
         icache_clr_entry <= icache_control_wr & w_data_r[`CPM_ICACHE_CONTROL_CLRE];
         icache_clr_all   <= icache_control_wr & w_data_r[`CPM_ICACHE_CONTROL_CLRA];
         icache_clr_addr  <= icache_op_address_r;
         status_word      <= psw_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operand port
   logic [63:0] field_sh;
   always_comb begin
      opd_reg  = reg_of(opd_sel);
      opd_pair = reg_of({opd_sel[3], opd_sel[2:0] + 3'h1});
      field_sh = {32'h0000_0000, opd_reg << bf_offset};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         opd_valid   <= 1'b0;
         opd_value   <= 64'h0;
         opd_field   <= 32'h0000_0000;
         opd_decimal <= 7'h00;
      end else begin
         opd_valid <= opd_req;
         if (opd_req) begin
            case (opd_size)
               cpm_pkg::CPM_SZ_BYTE: opd_value <= {56'h0, opd_reg[7:0]};
               cpm_pkg::CPM_SZ_WORD: opd_value <= {48'h0, opd_reg[15:0]};
               cpm_pkg::CPM_SZ_QUAD: opd_value <= {opd_reg, opd_pair};
               default:              opd_value <= {32'h0, opd_reg};
            endcase
            opd_field <= (bf_len == 5'h00) ? field_sh[31:0]
                         : field_sh[31:0] >> (6'd32 - {1'b0, bf_len});
            opd_decimal <= bcd_packed ? 7'(opd_reg[7:4]) * 7'd10 + 7'(opd_reg[3:0])
                                      : 7'(opd_reg[3:0]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // trace, vectors and space codes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trace_trap         <= 1'b0;
         vec_valid          <= 1'b0;
         vec_addr           <= 32'h0000_0000;
         space_code_outputs <= `CPM_FC_IDLE;
      end else begin
         trace_trap <= instr_done & (psw_r[`CPM_PSW_T0]
                       | (psw_r[`CPM_PSW_T1] & instr_flow));
         vec_valid  <= vec_req;
         if (vec_req) vec_addr <= vbr_r + {22'h0, vec_num, 2'b00};
         if (!bus_cycle) space_code_outputs <= `CPM_FC_IDLE;
         else if (bus_alt_src) space_code_outputs <= sfc_r;
         else if (bus_alt_dst) space_code_outputs <= dfc_r;
         else if (psw_r[`CPM_PSW_S])
            space_code_outputs <= bus_prog ? `CPM_FC_SPROG : `CPM_FC_SDATA;
         else space_code_outputs <= bus_prog ? `CPM_FC_UPROG : `CPM_FC_UDATA;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_both_held;
      aw_full_r && w_full_r && !s_bvalid;
   endsequence
   sequence s_resp_held;
      s_bvalid && !s_bready;
   endsequence

   AST_TRACE_ALL: assert property (instr_done && psw_r[`CPM_PSW_T0] |=> trace_trap)
      else $error("trace-all missed a trap");
   AST_TRACE_FLOW: assert property (instr_done && !psw_r[`CPM_PSW_T0]
      |=> trace_trap == $past(psw_r[`CPM_PSW_T1] && instr_flow))
      else $error("flow trace trap wrong");
   AST_A7_MSP: assert property (opd_req && opd_sel == 4'hF && opd_size == cpm_pkg::CPM_SZ_LONG
      && psw_r[`CPM_PSW_S] && psw_r[`CPM_PSW_M] |=> opd_value[31:0] == $past(msp_r))
      else $error("A7 did not select master stack");
   AST_VEC: assert property (vec_req |=> vec_valid
      && vec_addr == $past(vbr_r) + {22'h0, $past(vec_num), 2'b00})
      else $error("vector address wrong");
   AST_FC_USER: assert property (bus_cycle && !bus_alt_src && !bus_alt_dst
      && !psw_r[`CPM_PSW_S] |=> !space_code_outputs[2] && space_code_outputs != `CPM_FC_IDLE)
      else $error("user cycle shows supervisor space");
   AST_ALT_SRC: assert property (bus_cycle && bus_alt_src |=> space_code_outputs == $past(sfc_r))
      else $error("alternate source code not used");
   AST_ADDR_WORD: assert property (wb_en && wb_sel == 4'h9 && wb_size == cpm_pkg::CPM_SZ_WORD
      && !(do_write && wa == ADDR_W'(`CPM_OFF_GPR + 36))
      |=> gpr_r[9] == {{16{$past(wb_data[15])}}, $past(wb_data[15:0])})
      else $error("address word write not sign extended");
   AST_BYTE_KEEP: assert property (wb_en && wb_sel == 4'h2 && wb_size == cpm_pkg::CPM_SZ_BYTE
      && !(do_write && wa == ADDR_W'(`CPM_OFF_GPR + 8)) |=> gpr_r[2][31:8] == $past(gpr_r[2][31:8]))
      else $error("byte write disturbed upper bytes");
   AST_CLR_ALL: assert property (icache_control_wr && w_data_r[`CPM_ICACHE_CONTROL_CLRA]
      |=> icache_clr_all ##1 !icache_clr_all || icache_control_wr)
      else $error("cache clear pulse wrong");
   AST_BF_ONE: assert property (opd_req && bf_len == 5'h01 |=> opd_field[31:1] == 31'h0)
      else $error("one bit field too wide");
   AST_WR_RESP: assert property (s_both_held |=> s_bvalid)
      else $error("write answer missing");
   AST_RESP_HOLD: assert property (s_resp_held |=> s_bvalid && $stable(s_bresp))
      else $error("write answer dropped early");
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cpm_defines.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
   $display("wrong value at %0t: got %h exp %h", $time, a, b); end end
module tb_top;
///////////////////////////////////////////////////////////////////////////////
   logic        aclk = 1'h0, aresetn = 1'h0, s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
   logic        s_arvalid = 1'h0, s_rready = 1'h0, opd_req = 1'h0, bcd_packed = 1'h0;
   logic        wb_en = 1'h0, instr_done = 1'h0, instr_flow = 1'h0, vec_req = 1'h0;
   logic        bus_cycle = 1'h0, bus_prog = 1'h0, bus_alt_src = 1'h0, bus_alt_dst = 1'h0;
   logic [7:0]  s_awaddr = 8'h0, s_araddr = 8'h0, vec_num = 8'h0;
   logic [31:0] s_wdata = 32'h0, wb_data = 32'h0, k;
   logic [3:0]  s_wstrb = 4'hF, opd_sel = 4'h0, wb_sel = 4'h0;
   logic [4:0]  bf_offset = 5'h0, bf_len = 5'h0;
   cpm_pkg::cpm_size_e opd_size = cpm_pkg::CPM_SZ_LONG, wb_size = cpm_pkg::CPM_SZ_LONG;
   logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, opd_valid, trace_trap;
   logic        vec_valid, icache_enable, icache_freeze, icache_clr_entry, icache_clr_all;
   logic [1:0]  s_bresp, s_rresp;
   logic [2:0]  space_code_outputs;
   logic [15:0] status_word;
   logic [6:0]  opd_decimal;
   logic [63:0] opd_value;
   logic [31:0] s_rdata, opd_field, vec_addr, icache_clr_addr;
   int          mismatches = 0, n_compared = 0;

   cpm_regs DUT (.*);
   always #10 aclk = ~aclk;
///////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      s_awaddr  <= a;
      s_wdata   <= d;
      s_awvalid <= 1'h1;
      s_wvalid  <= 1'h1;
      s_bready  <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_awready === 1'h1) s_awvalid <= 1'h0;
         if (s_wready === 1'h1) s_wvalid <= 1'h0;
      end while (s_bvalid !== 1'h1);
      s_bready <= 1'h0;
      `CHK(s_bresp, r)
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
      s_araddr  <= a;
      s_arvalid <= 1'h1;
      s_rready  <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_arready === 1'h1) s_arvalid <= 1'h0;
      end while (s_rvalid !== 1'h1);
      s_rready <= 1'h0;
      `CHK(s_rdata, e)
      `CHK(s_rresp, r)
      tick(1);
   endtask
   task automatic op(input logic [3:0] s, input logic [4:0] l, input logic p,
                     input cpm_pkg::cpm_size_e z);
      opd_sel    <= s;
      bf_len     <= l;
      bcd_packed <= p;
      opd_size   <= z;
      opd_req    <= 1'h1;
      tick(1);
      opd_req <= 1'h0;
      tick(1);
      `CHK(opd_valid, 1'h1)
   endtask
   task automatic tr(input logic f);
      instr_flow <= f;
      instr_done <= 1'h1;
      tick(1);
      instr_done <= 1'h0;
      tick(1);
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
///////////////////////////////////////////////////////////////////////////////
   initial begin
      tick(2);
      aresetn <= 1'h1;
      tick(2);
      `CHK(status_word, `CPM_PSW_RESET)
      rd(`CPM_OFF_PSW, 32'h2700);
      for (k = 32'h0; k < 32'hF; k++) wr(8'(k * 32'h4), 32'h1111_1111 * (k + 32'h1));
      for (k = 32'h0; k < 32'hF; k++) rd(8'(k * 32'h4), 32'h1111_1111 * (k + 32'h1));
      op(4'h3, 5'h08, 1'h0, cpm_pkg::CPM_SZ_QUAD);
      `CHK(opd_value, 64'h4444_4444_5555_5555)
      `CHK(opd_field, 32'h44)
      `CHK(opd_decimal, 7'h04)
      op(4'h3, 5'h00, 1'h1, cpm_pkg::CPM_SZ_LONG);
      `CHK(opd_field, 32'h4444_4444)
      `CHK(opd_decimal, 7'h2C)
      wr(`CPM_OFF_ISP, 32'hA0);
      wr(`CPM_OFF_MSP, 32'hB0);
      op(4'hF, 5'h00, 1'h0, cpm_pkg::CPM_SZ_LONG);
      `CHK(opd_field, 32'hA0)
      wr(`CPM_OFF_PSW, 32'h3700);
      op(4'hF, 5'h00, 1'h0, cpm_pkg::CPM_SZ_LONG);
      `CHK(opd_field, 32'hB0)
      rd(`CPM_OFF_A7, 32'hB0);
      // word writeback to an address register sign-extends
      wb_sel  <= 4'h9;
      wb_size <= cpm_pkg::CPM_SZ_WORD;
      wb_data <= 32'h8000;
      wb_en   <= 1'h1;
      tick(1);
      wb_en <= 1'h0;
      rd(`CPM_OFF_GPR + 8'h24, 32'hFFFF_8000);
      wb_sel  <= 4'h2;
      wb_size <= cpm_pkg::CPM_SZ_BYTE;
      wb_data <= 32'hAB;
      wb_en   <= 1'h1;
      tick(1);
      wb_en <= 1'h0;
      rd(`CPM_OFF_GPR + 8'h08, 32'h3333_33AB);
      op(4'h9, 5'h01, 1'h0, cpm_pkg::CPM_SZ_LONG);
      `CHK(opd_field, 32'h1)
      wr(`CPM_OFF_PSW, 32'hFFFF_FFFF);
      rd(`CPM_OFF_PSW, 32'h0000_F71F);
      wr(`CPM_OFF_PSW, 32'h6000);
      tr(1'h0);
      `CHK(trace_trap, 1'h1)
      wr(`CPM_OFF_PSW, 32'hA000);
      tr(1'h0);
      `CHK(trace_trap, 1'h0)
      tr(1'h1);
      `CHK(trace_trap, 1'h1)
      bus_cycle <= 1'h1;
      bus_prog  <= 1'h1;
      tick(2);
      `CHK(space_code_outputs, `CPM_FC_SPROG)
      bus_prog <= 1'h0;
      tick(2);
      `CHK(space_code_outputs, `CPM_FC_SDATA)
      wr(`CPM_OFF_SFC, 32'hFFFF_FFFF);
      rd(`CPM_OFF_SFC, 32'h7);
      wr(`CPM_OFF_SFC, 32'h2);
      bus_alt_src <= 1'h1;
      tick(2);
      `CHK(space_code_outputs, `CPM_FC_UPROG)
      bus_alt_src <= 1'h0;
      wr(`CPM_OFF_PSW, 32'h0000);
      tick(2);
      `CHK(space_code_outputs, `CPM_FC_UDATA)
      wr(`CPM_OFF_VBR, 32'h1000);
      vec_num <= 8'h05;
      vec_req <= 1'h1;
      tick(1);
      vec_req <= 1'h0;
      tick(1);
      `CHK(vec_addr, 32'h1014)
      wr(`CPM_OFF_ICACHE_CONTROL, 32'hF);
      rd(`CPM_OFF_ICACHE_CONTROL, 32'h3);
      `CHK(icache_enable, 1'h1)
      `CHK(icache_freeze, 1'h1)
      wr(`CPM_OFF_ICACHE_OP_ADDRESS, 32'h100);
      tick(1);
      `CHK(icache_clr_addr, 32'h100)
      wr(8'h80, 32'h1, `CPM_RESP_SLVERR);
      rd(8'h80, 32'h0, `CPM_RESP_SLVERR);
      conclude();
   end
   initial begin
      tick(5000);
      mismatches++;
      conclude();
   end
endmodule
`default_nettype wire
